// ==== hif_regs.sv ====
// Module: interrupt mask, byte-order probe, FIFO thresholds and receive config
//
// Operation
// - Set enable bit lets its status source drive the interrupt; all reset to 0.
// - Status flags follow their sources whatever the enable bits hold.
// - Enables at 31, 25, 24, 23, 21, 20, 19 as listed.
// - Enables at 18, 17, 16, 15, 14, 13 as listed.
// - Bits 11 to 3 enable FIFO events; bits 2-0 the pin events.
// - Probe register always reads 87654321h.
// - Bits 31-24 TX space threshold, 64-byte blocks, reset 48h; flag when exceeded.
// - Bits 23-16 TX status threshold in DWORDs; flag when used exceeds it.
// - Bits 15-8 RX space threshold, 64-byte blocks; flag when free falls below.
// - Bits 7-0 RX status threshold in DWORDs; flag when used exceeds it.
// - Bits 31:30 pick 4, 16 or 32 byte end boundary; filler DWORDs added.
// - Bits 27-16 DWORD countdown, decremented per RX data DWORD read.
// - New countdown value accepted before zero; counting resumes from it.
// - Self-clearing bit 15 empties RX data and status FIFOs.
// - Bits 12-8 shift packet start by 0-31 bytes.
// - Upper three offset bits take effect from the next DWORD read.
// - RX DMA done raised when the programmed count has drained.
module hif_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host register port
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  // Interrupt status from the status register
  input wire logic [31:0] interrupt_status_reg,
  output logic irq,
  // FIFO occupancy
  input wire logic [7:0] tx_data_free_blocks,
  input wire logic [7:0] tx_status_used,
  input wire logic [7:0] rx_data_free_blocks,
  input wire logic [7:0] rx_status_used,
  output logic tx_space_avail_flag,
  output logic tx_status_level_flag,
  output logic rx_data_level_flag,
  output logic rx_status_level_flag,
  // Receive read path
  input wire logic rx_dword_read,
  input wire logic rx_packet_last,
  output logic rx_dma_done,
  output logic rx_fifo_discard,
  output logic [1:0] end_align,
  output logic [4:0] rx_start_offset,
  output logic [2:0] rx_filler_dwords,
  output logic rx_filler_valid
);
  import hif_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] interrupt_mask;
    logic [31:0] fifo_level_thresholds;
    logic [1:0] end_align;
    logic [11:0] rx_dword_countdown;
    logic [4:0] rx_start_offset;
    logic [2:0] dword_offset_live;
    logic [31:0] rdata;
    logic irq;
    logic tx_space_avail;
    logic tx_status_level;
    logic rx_data_level;
    logic rx_status_level;
    logic dma_done;
    logic discard;
    logic [2:0] filler;
    logic filler_valid;
  } hif_regs_state_t;

  hif_regs_state_t st;
  hif_regs_state_t next_st;

  hif_align_if align_link ();

  // Threshold field extraction, used for all four levels
  function automatic logic [7:0] hif_field8(input logic [31:0] word, input int lsb);
    hif_field8 = word[lsb +: 8];
  endfunction : hif_field8

  // ==========================================================================
  // Filler calculator
  hif_filler_calc u_filler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link(align_link.calc)
  );

  assign align_link.end_align = st.end_align;
  assign align_link.dword_pop = rx_dword_read;
  assign align_link.packet_last = rx_packet_last;
  assign align_link.discard = st.discard;

  // ==========================================================================
  // Next state
  always_comb begin
    logic wr_mask;
    logic wr_thr;
    logic wr_rxcfg;
    logic [31:0] rd_word;
    rd_word = 32'h0000_0000;
    next_st = st;
    wr_mask = host_wr && (host_addr == OFS_INTERRUPT_MASK);
    wr_thr = host_wr && (host_addr == OFS_FIFO_LEVEL_THRESHOLDS);
    wr_rxcfg = host_wr && (host_addr == OFS_RECEIVE_CONFIG);

    // Writable enables only; reserved positions keep zero
    if (wr_mask) begin
      next_st.interrupt_mask = host_wdata & INTERRUPT_MASK_WRITABLE;
    end
    if (wr_thr) begin
      next_st.fifo_level_thresholds = host_wdata;
    end

    // Countdown: host write wins over a same-cycle read so the new value counts
    next_st.dma_done = 1'b0;
    if (wr_rxcfg) begin
      next_st.end_align = host_wdata[FLD_END_ALIGN_LSB +: 2];
      next_st.rx_dword_countdown = host_wdata[FLD_DWORD_COUNT_LSB +: 12];
      next_st.rx_start_offset = host_wdata[FLD_START_OFFSET_LSB +: 5];
    end else if (rx_dword_read && (st.rx_dword_countdown != 12'h000)) begin
      next_st.rx_dword_countdown = st.rx_dword_countdown - 12'h001;
      if (st.rx_dword_countdown == 12'h001) begin
        next_st.dma_done = 1'b1;
      end
    end

    // Discard is a one-cycle pulse; the bit never stores
    next_st.discard = wr_rxcfg && host_wdata[BIT_RX_DISCARD];

    // Upper offset bits move to the datapath only on a DWORD read
    if (rx_dword_read) begin
      next_st.dword_offset_live = st.rx_start_offset[4:2];
    end

    // Level flags run regardless of enables
    next_st.tx_space_avail =
      tx_data_free_blocks > hif_field8(st.fifo_level_thresholds, FLD_TX_SPACE_LSB);
    next_st.tx_status_level =
      tx_status_used > hif_field8(st.fifo_level_thresholds, FLD_TX_STATUS_LSB);
    next_st.rx_data_level =
      rx_data_free_blocks < hif_field8(st.fifo_level_thresholds, FLD_RX_SPACE_LSB);
    next_st.rx_status_level =
      rx_status_used > hif_field8(st.fifo_level_thresholds, FLD_RX_STATUS_LSB);

    next_st.irq = |(interrupt_status_reg & st.interrupt_mask);

    next_st.filler = align_link.filler_dwords;
    next_st.filler_valid = align_link.filler_valid;

    // Read mux; unmapped addresses and reserved bits give zero
    case (host_addr)
      OFS_INTERRUPT_MASK: begin
        rd_word = st.interrupt_mask;
      end
      OFS_BYTE_ORDER_PROBE: begin
        rd_word = BYTE_ORDER_PATTERN;
      end
      OFS_FIFO_LEVEL_THRESHOLDS: begin
        rd_word = st.fifo_level_thresholds;
      end
      OFS_RECEIVE_CONFIG: begin
        rd_word[FLD_END_ALIGN_LSB +: 2] = st.end_align;
        rd_word[FLD_DWORD_COUNT_LSB +: 12] = st.rx_dword_countdown;
        rd_word[FLD_START_OFFSET_LSB +: 5] = st.rx_start_offset;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    if (host_rd) begin
      next_st.rdata = rd_word;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.interrupt_mask <= INTERRUPT_MASK_RESET;
      st.fifo_level_thresholds <= FIFO_LEVEL_THRESHOLDS_RESET;
      st.end_align <= END_ALIGN_RESET;
      st.rx_dword_countdown <= DWORD_COUNT_RESET;
      st.rx_start_offset <= START_OFFSET_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign host_rdata = st.rdata;
  assign irq = st.irq;
  assign tx_space_avail_flag = st.tx_space_avail;
  assign tx_status_level_flag = st.tx_status_level;
  assign rx_data_level_flag = st.rx_data_level;
  assign rx_status_level_flag = st.rx_status_level;
  assign rx_dma_done = st.dma_done;
  assign rx_fifo_discard = st.discard;
  assign end_align = st.end_align;
  // Low two bits apply at once: host only changes them with reception halted
  assign rx_start_offset = {st.dword_offset_live, st.rx_start_offset[1:0]};
  assign rx_filler_dwords = st.filler;
  assign rx_filler_valid = st.filler_valid;
endmodule : hif_regs

// ==== hif_pkg.sv ====
// Package: offsets, field positions, reset values and masks of the register group
package hif_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_INTERRUPT_MASK = 8'h5C;
  localparam logic [7:0] OFS_BYTE_ORDER_PROBE = 8'h64;
  localparam logic [7:0] OFS_FIFO_LEVEL_THRESHOLDS = 8'h68;
  localparam logic [7:0] OFS_RECEIVE_CONFIG = 8'h6C;

  // ==========================================================================
  // Interrupt enable bit positions
  localparam int BIT_SOFTWARE_IRQ_ENABLE = 31;
  localparam int BIT_TX_HALTED_ENABLE = 25;
  localparam int BIT_RX_HALTED_ENABLE = 24;
  localparam int BIT_DROP_COUNTER_HALF_ENABLE = 23;
  localparam int BIT_TX_BUFFER_DONE_ENABLE = 21;
  localparam int BIT_RX_DMA_DONE_ENABLE = 20;
  localparam int BIT_GP_TIMER_ENABLE = 19;
  localparam int BIT_PHY_EVENT_ENABLE = 18;
  localparam int BIT_POWER_EVENT_ENABLE = 17;
  localparam int BIT_TX_STATUS_OVERFLOW_ENABLE = 16;
  localparam int BIT_RX_WATCHDOG_ENABLE = 15;
  localparam int BIT_RX_ERROR_ENABLE = 14;
  localparam int BIT_TX_ERROR_ENABLE = 13;
  localparam int BIT_TX_DATA_UNDERRUN_ENABLE = 11;
  localparam int BIT_TX_DATA_OVERRUN_ENABLE = 10;
  localparam int BIT_TX_SPACE_AVAIL_ENABLE = 9;
  localparam int BIT_TX_STATUS_FULL_ENABLE = 8;
  localparam int BIT_TX_STATUS_LEVEL_ENABLE = 7;
  localparam int BIT_RX_DROP_ENABLE = 6;
  localparam int BIT_RX_DATA_LEVEL_ENABLE = 5;
  localparam int BIT_RX_STATUS_FULL_ENABLE = 4;
  localparam int BIT_RX_STATUS_LEVEL_ENABLE = 3;
  localparam int BIT_PIN_EVENT_ENABLES_LSB = 0;
  localparam logic [31:0] INTERRUPT_MASK_WRITABLE = 32'h83BF_EFFF;
  localparam logic [31:0] INTERRUPT_MASK_RESET = 32'h0000_0000;

  // ==========================================================================
  // Fixed byte-order pattern
  localparam logic [31:0] BYTE_ORDER_PATTERN = 32'h8765_4321;

  // ==========================================================================
  // FIFO level threshold fields
  localparam int FLD_TX_SPACE_LSB = 24;
  localparam int FLD_TX_STATUS_LSB = 16;
  localparam int FLD_RX_SPACE_LSB = 8;
  localparam int FLD_RX_STATUS_LSB = 0;
  localparam logic [31:0] FIFO_LEVEL_THRESHOLDS_RESET = 32'h4800_0000;

  // ==========================================================================
  // Receive configuration fields
  localparam int FLD_END_ALIGN_LSB = 30;
  localparam int FLD_DWORD_COUNT_LSB = 16;
  localparam int BIT_RX_DISCARD = 15;
  localparam int FLD_START_OFFSET_LSB = 8;
  localparam logic [1:0] END_ALIGN_RESET = 2'h0;
  localparam logic [11:0] DWORD_COUNT_RESET = 12'h000;
  localparam logic [4:0] START_OFFSET_RESET = 5'h00;

  // End alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;

  // Boundary sizes in DWORDs for each alignment code
  localparam logic [3:0] DWORDS_PER_4 = 4'h1;
  localparam logic [3:0] DWORDS_PER_16 = 4'h4;
  localparam logic [3:0] DWORDS_PER_32 = 4'h8;

endpackage : hif_pkg

// ==== hif_align_if.sv ====
// Interface: receive read tracking between register group and filler calculator
interface hif_align_if;
  logic [1:0] end_align;
  logic dword_pop;
  logic packet_last;
  logic discard;
  logic [2:0] filler_dwords;
  logic filler_valid;

  modport regs (
    output end_align,
    output dword_pop,
    output packet_last,
    output discard,
    input filler_dwords,
    input filler_valid
  );

  modport calc (
    input end_align,
    input dword_pop,
    input packet_last,
    input discard,
    output filler_dwords,
    output filler_valid
  );
endinterface : hif_align_if

// ==== hif_filler_calc.sv ====
// Module: counts DWORDs of the packet being read and works out end filler
module hif_filler_calc (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register group side
  hif_align_if.calc link
);
  import hif_pkg::*;

  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] filler;
    logic valid;
  } hif_calc_state_t;

  hif_calc_state_t st;
  hif_calc_state_t next_st;

  // Boundary in DWORDs; the reserved code falls back to 4 bytes
  function automatic logic [3:0] hif_boundary(input logic [1:0] code);
    case (code)
      ALIGN_16: hif_boundary = DWORDS_PER_16;
      ALIGN_32: hif_boundary = DWORDS_PER_32;
      default: hif_boundary = DWORDS_PER_4;
    endcase
  endfunction : hif_boundary

  always_comb begin
    logic [3:0] bnd;
    logic [3:0] used;
    logic [3:0] rem;
    bnd = hif_boundary(link.end_align);
    used = {1'b0, st.pos} + 4'h1;
    rem = (bnd - (used & (bnd - 4'h1))) & (bnd - 4'h1);
    next_st = st;
    next_st.valid = 1'b0;
    if (link.discard) begin
      next_st.pos = 3'h0;
    end else if (link.dword_pop) begin
      if (link.packet_last) begin
        next_st.pos = 3'h0;
        next_st.filler = rem[2:0];
        next_st.valid = 1'b1;
      end else begin
        next_st.pos = used[2:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.filler_dwords = st.filler;
  assign link.filler_valid = st.valid;
endmodule : hif_filler_calc

// ==== hif_chk.sv ====
// Checker: port-level properties of the register group
module hif_chk import hif_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host side
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  // Status, levels and flags
  input wire logic [31:0] interrupt_status_reg,
  input wire logic irq,
  input wire logic [7:0] tx_data_free_blocks,
  input wire logic [7:0] tx_status_used,
  input wire logic [7:0] rx_data_free_blocks,
  input wire logic [7:0] rx_status_used,
  input wire logic tx_space_avail_flag,
  input wire logic tx_status_level_flag,
  input wire logic rx_data_level_flag,
  input wire logic rx_status_level_flag,
  // Receive path
  input wire logic rx_dword_read,
  input wire logic rx_dma_done,
  input wire logic rx_fifo_discard,
  input wire logic [1:0] end_align
);
  // ==========================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] wr_align;
  assign wr_align = host_wdata[31:30];
  a_probe_read: assert property (
    host_rd && host_addr == OFS_BYTE_ORDER_PROBE |=> host_rdata == BYTE_ORDER_PATTERN)
    else $error("Probe read wrong");
  a_irq_cause: assert property (
    irq |-> $past(interrupt_status_reg) != 32'h0) else $error("Irq without status");
  a_tx_space_min: assert property (
    tx_data_free_blocks == 8'h00 |=> !tx_space_avail_flag) else $error("Tx space flag");
  a_tx_stat_min: assert property (
    tx_status_used == 8'h00 |=> !tx_status_level_flag) else $error("Tx status flag");
  a_rx_space_max: assert property (
    rx_data_free_blocks == 8'hFF |=> !rx_data_level_flag) else $error("Rx level flag");
  a_rx_stat_min: assert property (
    rx_status_used == 8'h00 |=> !rx_status_level_flag) else $error("Rx status flag");
  a_done_pulse: assert property (
    rx_dma_done |-> $past(rx_dword_read) ##1 !rx_dma_done) else $error("Done pulse");
  a_discard_set: assert property (
    host_wr && host_addr == OFS_RECEIVE_CONFIG && host_wdata[15] |=> rx_fifo_discard)
    else $error("Discard missing");
  a_discard_clr: assert property (
    rx_fifo_discard |=> !rx_fifo_discard || $past(host_wr)) else $error("Discard stuck");
  a_align_load: assert property (
    host_wr && host_addr == OFS_RECEIVE_CONFIG |=> end_align == $past(wr_align))
    else $error("Align not loaded");
endmodule : hif_chk

bind hif_regs hif_chk u_chk (.core_clk, .rst_n, .host_addr, .host_wr, .host_rd,
  .host_wdata, .host_rdata, .interrupt_status_reg, .irq, .tx_data_free_blocks,
  .tx_status_used, .rx_data_free_blocks, .rx_status_used, .tx_space_avail_flag,
  .tx_status_level_flag, .rx_data_level_flag, .rx_status_level_flag, .rx_dword_read,
  .rx_dma_done, .rx_fifo_discard, .end_align);

// ==== hif_host.sv ====
// Host processor model: register cycles and RX data reads
module hif_host (
  // Clock
  input wire logic core_clk,
  // Register bus
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [31:0] host_wdata,
  // RX data reads
  output logic rx_dword_read,
  output logic rx_packet_last
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Bus cycles
  initial begin
    {host_addr, host_wr, host_rd, host_wdata} = '0;
    {rx_dword_read, rx_packet_last} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr = w;
    host_rd = !w;
    @(posedge core_clk);
    #1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    // Released lines show no stale value
    host_addr = ~a;
    host_wdata = ~d;
  endtask : xfer
  task automatic pop(input logic last);
    @(posedge core_clk);
    #1;
    rx_dword_read = 1'b1;
    rx_packet_last = last;
    @(posedge core_clk);
    #1;
    rx_dword_read = 1'b0;
    rx_packet_last = 1'b0;
  endtask : pop
  // Whole packets only, so alignment never moves mid-packet
  task automatic pkt(input int n);
    for (int i = 1; i <= n; i++)
      pop(i == n);
    // Filler words after the packet are dropped, never forwarded
  endtask : pkt
endmodule : hif_host

// ==== test_host_irq_fifo_rx_config.sv ====
// Testbench: self-checking run of the register group
module test_host_irq_fifo_rx_config import hif_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] interrupt_status_reg = '0;
  logic [7:0] tx_data_free_blocks = '0, tx_status_used = '0;
  logic [7:0] rx_data_free_blocks = '0, rx_status_used = '0;
  logic [7:0] host_addr;
  logic host_wr, host_rd, rx_dword_read, rx_packet_last;
  logic [31:0] host_wdata, host_rdata;
  logic irq, tx_space_avail_flag, tx_status_level_flag, rx_data_level_flag;
  logic rx_status_level_flag, rx_dma_done, rx_fifo_discard, rx_filler_valid;
  logic [1:0] end_align;
  logic [4:0] rx_start_offset;
  logic [2:0] rx_filler_dwords;
  logic [2:0] fil [4] = '{3'h0, 3'h1, 3'h5, 3'h0};
  logic [31:0] exp_q [$];
  logic rd_d = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  always #5 core_clk = ~core_clk;
  hif_host u_host (.core_clk, .host_addr, .host_wr, .host_rd, .host_wdata,
    .rx_dword_read, .rx_packet_last);
  hif_regs dut (.core_clk, .rst_n, .host_addr, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .interrupt_status_reg, .irq, .tx_data_free_blocks, .tx_status_used,
    .rx_data_free_blocks, .rx_status_used, .tx_space_avail_flag, .tx_status_level_flag,
    .rx_data_level_flag, .rx_status_level_flag, .rx_dword_read, .rx_packet_last,
    .rx_dma_done, .rx_fifo_discard, .end_align, .rx_start_offset, .rx_filler_dwords,
    .rx_filler_valid);
  // ==========================================
  // Helpers
  task automatic cmp_pin(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_pin
  task automatic cmp_rd(input logic [31:0] g);
    if (exp_q.size() == 0) begin
      // A read with no note is a mismatch, even if the data is unknown
      cmp_count++;
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, 32'h0000_0000);
    end else begin
      cmp_pin(g, exp_q.pop_front());
    end
  endtask : cmp_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Read data lands one edge after the read is taken
  always @(posedge core_clk) begin
    if (rd_d)
      cmp_rd(host_rdata);
    rd_d <= host_rd;
  end
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  // ==========================================
  // Tests
  initial begin
    logic [31:0] v;
    logic [31:0] t;
    v = $urandom(32'h1DCA);
    tick(5);
    rst_n = 1'b1;
    rd(OFS_INTERRUPT_MASK, INTERRUPT_MASK_RESET);
    rd(OFS_FIFO_LEVEL_THRESHOLDS, FIFO_LEVEL_THRESHOLDS_RESET);
    rd(OFS_RECEIVE_CONFIG, 32'h0);
    wr(OFS_BYTE_ORDER_PROBE, $urandom());
    rd(OFS_BYTE_ORDER_PROBE, BYTE_ORDER_PATTERN);
    rd(8'h70, 32'h0);
    v = $urandom();
    wr(OFS_INTERRUPT_MASK, v);
    rd(OFS_INTERRUPT_MASK, v & INTERRUPT_MASK_WRITABLE);
    for (int b = 0; b < 32; b++) begin
      t = 32'h1 << b;
      wr(OFS_INTERRUPT_MASK, t);
      interrupt_status_reg = ~t;
      tick(2);
      cmp_pin(irq, 1'b0);
      interrupt_status_reg = t;
      tick(2);
      cmp_pin(irq, INTERRUPT_MASK_WRITABLE[b]);
    end
    t = $urandom();
    wr(OFS_FIFO_LEVEL_THRESHOLDS, t);
    rd(OFS_FIFO_LEVEL_THRESHOLDS, t);
    repeat (40) begin
      // Levels near each threshold to hit the equal case
      {tx_data_free_blocks, tx_status_used, rx_data_free_blocks, rx_status_used} =
        t ^ ($urandom() & 32'h0303_0303);
      tick(2);
      cmp_pin(tx_space_avail_flag, tx_data_free_blocks > t[31:24]);
      cmp_pin(tx_status_level_flag, tx_status_used > t[23:16]);
      cmp_pin(rx_data_level_flag, rx_data_free_blocks < t[15:8]);
      cmp_pin(rx_status_level_flag, rx_status_used > t[7:0]);
    end
    // Extreme levels: no threshold value can raise any flag here
    {tx_data_free_blocks, tx_status_used, rx_data_free_blocks, rx_status_used} = 32'h0000_FF00;
    tick(2);
    cmp_pin({tx_space_avail_flag, tx_status_level_flag, rx_data_level_flag,
      rx_status_level_flag}, 4'h0);
    wr(OFS_RECEIVE_CONFIG, 32'h0000_8000);
    cmp_pin(rx_fifo_discard, 1'b1);
    tick(1);
    cmp_pin(rx_fifo_discard, 1'b0);
    rd(OFS_RECEIVE_CONFIG, 32'h0);
    wr(OFS_RECEIVE_CONFIG, 32'h0005_0000);
    u_host.pkt(2);
    wr(OFS_RECEIVE_CONFIG, 32'h0002_0000);
    u_host.pop(1'b0);
    cmp_pin(rx_dma_done, 1'b0);
    u_host.pop(1'b1);
    cmp_pin(rx_dma_done, 1'b1);
    rd(OFS_RECEIVE_CONFIG, 32'h0);
    for (int b = 0; b < 4; b++) begin
      wr(OFS_RECEIVE_CONFIG, 32'(b) << 30);
      cmp_pin(end_align, b[1:0]);
      u_host.pkt(3);
      // Filler result passes through the calculator and then the output stage
      tick(1);
      cmp_pin({rx_filler_valid, rx_filler_dwords}, {1'b1, fil[b]});
    end
    // Low two offset bits stay zero while receiving
    wr(OFS_RECEIVE_CONFIG, 32'h0000_1C00);
    cmp_pin(rx_start_offset, 5'h00);
    u_host.pop(1'b1);
    tick(1);
    cmp_pin(rx_start_offset, 5'h1C);
    rd(OFS_RECEIVE_CONFIG, 32'h0000_1C00);
    tick(3);
    wrap_up();
  end
endmodule : test_host_irq_fifo_rx_config
